// File: design/auto_wake_sleep_idle_timing.sv
// auto wake/rest timing: idle times, inactivity counter and register slave
`default_nettype none
module auto_wake_sleep_idle_timing #(
    parameter int STEP_COUNT = wake_rest_pkg::STEP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire wake_rest_pkg::event_flags_type event_flags,
    input wire logic buffer_empty,
    output logic rest_mode,
    output logic period_strobe,
    output logic buffer_input_blocked,
    output logic irq
);
    import wake_rest_pkg::*;

    // ---------------- bus slave ----------------
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_have_q, w_have_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    wire aw_take = s_axi_awvalid & awready_q;
    wire w_take = s_axi_wvalid & wready_q;
    wire do_write = aw_have_q & w_have_q & ~bvalid_q;
    wire aw_have_d = (aw_have_q & ~do_write) | aw_take;
    wire w_have_d = (w_have_q & ~do_write) | w_take;
    wire bvalid_d = (bvalid_q & ~s_axi_bready) | do_write;
    wire ar_take = s_axi_arvalid & arready_q;
    wire rvalid_d = (rvalid_q & ~s_axi_rready) | ar_take;

    wire [5:0] widx = waddr_q[7:2];
    wire [5:0] ridx = s_axi_araddr[7:2];
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire lane0 = do_write & wstrb_q[0];
    wire [7:0] wbyte = wdata_q[7:0];

    // ---------------- registers ----------------
    logic [7:0] act_idle_lo_q, rest_idle_lo_q, limit_lo_q;
    logic [3:0] act_idle_hi_q, rest_idle_hi_q, limit_hi_q;
    logic [31:0] mode_ctrl_q, rate_ctrl_q;
    logic [1:0] irq_status_q, irq_mask_q;

    wire [11:0] active_idle_time = {act_idle_hi_q, act_idle_lo_q};
    wire [11:0] rest_idle_time = {rest_idle_hi_q, rest_idle_lo_q};
    wire [11:0] inactivity_limit = {limit_hi_q, limit_lo_q};

    wire mode_config_type active_cfg = '{
        power_select: mode_ctrl_q[ACT_PWR_LSB +: 2],
        rate_select: rate_ctrl_q[ACT_RATE_LSB +: 4],
        decimation: rate_ctrl_q[ACT_DEC_LSB +: 3],
        idle_time: active_idle_time};
    wire mode_config_type rest_cfg = '{
        power_select: mode_ctrl_q[REST_PWR_LSB +: 2],
        rate_select: rate_ctrl_q[REST_RATE_LSB +: 4],
        decimation: rate_ctrl_q[REST_DEC_LSB +: 3],
        idle_time: rest_idle_time};
    wire buffer_wake_option = mode_ctrl_q[BUF_WAKE_BIT];
    wire buffer_gate = mode_ctrl_q[BUF_GATE_BIT];
    wire [2:0] detect_enable = mode_ctrl_q[DET_EN_LSB +: 3];

    mode_type mode_q;
    logic [15:0] step_cnt_q;
    logic [13:0] period_cnt_q;
    logic [11:0] inact_cnt_q;
    logic buf_flag_q;
    logic gate_hold_q;
    logic period_strobe_q;
    logic irq_q;

    wire wmapped = widx >= IDX_ACTIVE_IDLE_LOW[5:0] && widx <= IDX_IRQ_MASK[5:0];
    wire rmapped = ridx >= IDX_ACTIVE_IDLE_LOW[5:0] && ridx <= IDX_IRQ_MASK[5:0];

    // ---------------- read decode ----------------
    wire [31:0] status_word = {16'h0000, inact_cnt_q, 2'h0, gate_hold_q, mode_q == MODE_REST};
    wire [31:0] rd_word =
        (ridx == IDX_ACTIVE_IDLE_LOW[5:0]) ? {24'h0, act_idle_lo_q} :
        (ridx == IDX_ACTIVE_IDLE_HIGH[5:0]) ? {28'h0, act_idle_hi_q} :
        (ridx == IDX_REST_IDLE_LOW[5:0]) ? {24'h0, rest_idle_lo_q} :
        (ridx == IDX_REST_IDLE_HIGH[5:0]) ? {28'h0, rest_idle_hi_q} :
        (ridx == IDX_INACT_COUNT_LOW[5:0]) ? {24'h0, limit_lo_q} :
        (ridx == IDX_INACT_COUNT_HIGH[5:0]) ? {28'h0, limit_hi_q} :
        (ridx == IDX_MODE_CONTROL[5:0]) ? mode_ctrl_q :
        (ridx == IDX_RATE_CONTROL[5:0]) ? rate_ctrl_q :
        (ridx == IDX_STATUS[5:0]) ? status_word :
        (ridx == IDX_IRQ_STATUS[5:0]) ? {30'h0, irq_status_q} :
        (ridx == IDX_IRQ_MASK[5:0]) ? {30'h0, irq_mask_q} : RESET_WORD;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= RESET_WORD;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            rdata_q <= RESET_WORD;
        end else begin
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q <= ~w_have_d & ~bvalid_d;
            arready_q <= ~rvalid_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            if (aw_take) begin
                waddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bresp_q <= wmapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (ar_take) begin
                rdata_q <= rd_word;
                rresp_q <= rmapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ---------------- period and mode logic ----------------

    // measurement time is 2^decimation steps; fixed-rate period is 2^rate steps, with rate capped at 12
    wire [3:0] act_rate = (active_cfg.rate_select > MAX_RATE_SELECT) ? MAX_RATE_SELECT
                                                                      : active_cfg.rate_select;
    wire [3:0] rest_rate = (rest_cfg.rate_select > MAX_RATE_SELECT) ? MAX_RATE_SELECT
                                                                     : rest_cfg.rate_select;
    wire [13:0] act_len = active_cfg.power_select[FLEXIBLE_BIT] ?
        {2'h0, active_cfg.idle_time} + (14'h1 << active_cfg.decimation) :
        (14'h1 << act_rate);
    wire [13:0] rest_len = rest_cfg.power_select[FLEXIBLE_BIT] ?
        {2'h0, rest_cfg.idle_time} + (14'h1 << rest_cfg.decimation) :
        (14'h1 << rest_rate);
    wire [13:0] period_len = (mode_q == MODE_ACTIVE) ? act_len : rest_len;

    wire step_pulse = step_cnt_q == 16'(STEP_COUNT - 1);
    wire period_end = step_pulse && period_cnt_q >= period_len - 14'h1;

    // buffer flag is excluded from waking; its clearing by the host only restarts the timer
    wire wake_event = |(detect_enable & {event_flags.outside_threshold_flag,
                                         event_flags.within_threshold_flag,
                                         event_flags.orientation_flag});
    wire buf_clear = buffer_wake_option & buf_flag_q & ~event_flags.buffer_event_flag;
    wire timer_clear = wake_event | buf_clear;
    wire auto_on = inactivity_limit != 12'h000;
    wire [11:0] inact_next = inact_cnt_q + 12'h001;
    wire go_rest = (mode_q == MODE_ACTIVE) & auto_on & ~timer_clear & period_end
                   & (inact_next >= inactivity_limit);
    wire go_active = (mode_q == MODE_REST) & (wake_event | ~auto_on);
    wire transition = go_rest | go_active;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_cnt_q <= 16'h0000;
            period_cnt_q <= 14'h0000;
        end else begin
            step_cnt_q <= step_pulse ? 16'h0000 : step_cnt_q + 16'h0001;
            if (transition || period_end) begin
                period_cnt_q <= 14'h0000;
            end else if (step_pulse) begin
                period_cnt_q <= period_cnt_q + 14'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= MODE_ACTIVE;
            inact_cnt_q <= 12'h000;
        end else begin
            if (go_rest) begin
                mode_q <= MODE_REST;
            end else if (go_active) begin
                mode_q <= MODE_ACTIVE;
            end
            if (transition || timer_clear || !auto_on || mode_q == MODE_REST) begin
                inact_cnt_q <= 12'h000;
            end else if (period_end) begin
                inact_cnt_q <= inact_next;
            end
        end
    end

    wire [1:0] irq_set = {go_active, go_rest};
    wire [1:0] irq_clr = (do_write && widx == IDX_IRQ_STATUS[5:0] && wstrb_q[0]) ?
                         wdata_q[1:0] : 2'h0;
    // set wins over clear so an event in the clearing cycle is kept
    wire [1:0] irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_flag_q <= 1'b0;
            gate_hold_q <= 1'b0;
            period_strobe_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            buf_flag_q <= event_flags.buffer_event_flag;
            // a new transition wins over the buffer draining in the same cycle
            if (transition && buffer_gate) begin
                gate_hold_q <= 1'b1;
            end else if (buffer_empty) begin
                gate_hold_q <= 1'b0;
            end
            period_strobe_q <= period_end;
            irq_q <= |(irq_status_d & irq_mask_q);
        end
    end

    // ---------------- register writes ----------------

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_idle_lo_q <= RESET_BYTE;
            act_idle_hi_q <= RESET_BYTE[3:0];
            rest_idle_lo_q <= RESET_BYTE;
            rest_idle_hi_q <= RESET_BYTE[3:0];
            limit_lo_q <= RESET_BYTE;
            limit_hi_q <= RESET_BYTE[3:0];
            mode_ctrl_q <= RESET_WORD;
            rate_ctrl_q <= RESET_WORD;
            irq_status_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            irq_status_q <= irq_status_d;
            if (lane0 && widx == IDX_ACTIVE_IDLE_LOW[5:0]) begin
                act_idle_lo_q <= wbyte;
            end
            if (lane0 && widx == IDX_ACTIVE_IDLE_HIGH[5:0]) begin
                act_idle_hi_q <= wbyte[3:0];
            end
            if (lane0 && widx == IDX_REST_IDLE_LOW[5:0]) begin
                rest_idle_lo_q <= wbyte;
            end
            if (lane0 && widx == IDX_REST_IDLE_HIGH[5:0]) begin
                rest_idle_hi_q <= wbyte[3:0];
            end
            if (lane0 && widx == IDX_INACT_COUNT_LOW[5:0]) begin
                limit_lo_q <= wbyte;
            end
            if (lane0 && widx == IDX_INACT_COUNT_HIGH[5:0]) begin
                limit_hi_q <= wbyte[3:0];
            end
            if (do_write && widx == IDX_MODE_CONTROL[5:0]) begin
                mode_ctrl_q <= ((mode_ctrl_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_01FF;
            end
            if (do_write && widx == IDX_RATE_CONTROL[5:0]) begin
                rate_ctrl_q <= ((rate_ctrl_q & ~wmask) | (wdata_q & wmask)) & 32'h0000_77FF;
            end
            if (lane0 && widx == IDX_IRQ_MASK[5:0]) begin
                irq_mask_q <= wbyte[1:0];
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign rest_mode = mode_q == MODE_REST;
    assign period_strobe = period_strobe_q;
    assign buffer_input_blocked = gate_hold_q;
    assign irq = irq_q;

    // ---------------- assertions ----------------
    property p_wake_exit;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q == MODE_REST && wake_event) |=> (mode_q == MODE_ACTIVE);
    endproperty
    a_wake_exit: assert property (p_wake_exit) else $error("rest kept despite wake event");

    property p_zero_limit;
        @(posedge aclk) disable iff (!aresetn)
        (inactivity_limit == 12'h000) [*2] |-> (mode_q == MODE_ACTIVE);
    endproperty
    a_zero_limit: assert property (p_zero_limit) else $error("rest with zero count");

    property p_enter_rest;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q == MODE_ACTIVE && auto_on && !timer_clear && period_end
         && inact_cnt_q + 12'h001 == inactivity_limit) |=> (mode_q == MODE_REST);
    endproperty
    a_enter_rest: assert property (p_enter_rest) else $error("no rest at count limit");

    property p_no_early_rest;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q == MODE_ACTIVE && inact_cnt_q + 12'h001 < inactivity_limit)
        |=> (mode_q == MODE_ACTIVE);
    endproperty
    a_no_early_rest: assert property (p_no_early_rest) else $error("rest before limit");

    property p_clear_on_event;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q == MODE_ACTIVE && wake_event) |=> (inact_cnt_q == 12'h000);
    endproperty
    a_clear_on_event: assert property (p_clear_on_event) else $error("event kept timer");

    property p_buffer_clear;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q == MODE_ACTIVE && buffer_wake_option && $fell(event_flags.buffer_event_flag))
        |=> (inact_cnt_q == 12'h000 && mode_q == $past(mode_q));
    endproperty
    a_buffer_clear: assert property (p_buffer_clear) else $error("buffer clear ignored");

    property p_advance;
        @(posedge aclk) disable iff (!aresetn)
        (mode_q == MODE_ACTIVE && auto_on && !timer_clear && period_end && !go_rest)
        |=> (inact_cnt_q == $past(inact_cnt_q) + 12'h001) && period_strobe;
    endproperty
    a_advance: assert property (p_advance) else $error("counter did not advance");

    property p_flex_len;
        @(posedge aclk) disable iff (!aresetn)
        active_cfg.power_select[FLEXIBLE_BIT] |->
        (act_len == {2'h0, active_idle_time} + (14'h1 << active_cfg.decimation));
    endproperty
    a_flex_len: assert property (p_flex_len) else $error("flexible period wrong");

    property p_gate;
        @(posedge aclk) disable iff (!aresetn)
        (transition && buffer_gate) |=> buffer_input_blocked ##1 (buffer_input_blocked
        || $past(buffer_empty));
    endproperty
    a_gate: assert property (p_gate) else $error("buffer not blocked after transition");

    property p_step_len;
        @(posedge aclk) disable iff (!aresetn)
        step_pulse |=> (step_cnt_q == 16'h0000) ##1 !step_pulse;
    endproperty
    a_step_len: assert property (p_step_len) else $error("step counter wrapped wrong");
endmodule
`default_nettype wire

// File: design/wake_rest_pkg.sv
// package: register map, field layout, reset values and timing for the wake/rest timing block
`default_nettype none
package wake_rest_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_ACTIVE_IDLE_LOW = 8'h1A;
    localparam logic [7:0] IDX_ACTIVE_IDLE_HIGH = 8'h1B;
    localparam logic [7:0] IDX_REST_IDLE_LOW = 8'h1C;
    localparam logic [7:0] IDX_REST_IDLE_HIGH = 8'h1D;
    localparam logic [7:0] IDX_INACT_COUNT_LOW = 8'h1E;
    localparam logic [7:0] IDX_INACT_COUNT_HIGH = 8'h1F;
    localparam logic [7:0] IDX_MODE_CONTROL = 8'h20;
    localparam logic [7:0] IDX_RATE_CONTROL = 8'h21;
    localparam logic [7:0] IDX_STATUS = 8'h22;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h23;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h24;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // mode control fields
    localparam int ACT_PWR_LSB = 0;
    localparam int REST_PWR_LSB = 2;
    localparam int BUF_WAKE_BIT = 4;
    localparam int BUF_GATE_BIT = 5;
    localparam int DET_EN_LSB = 6;
    // rate control fields
    localparam int ACT_RATE_LSB = 0;
    localparam int REST_RATE_LSB = 4;
    localparam int ACT_DEC_LSB = 8;
    localparam int REST_DEC_LSB = 12;
    // status fields
    localparam int STAT_REST_BIT = 0;
    localparam int STAT_GATE_BIT = 1;
    localparam int STAT_COUNT_LSB = 4;
    // interrupt status / mask bits
    localparam int IRQ_REST_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;

    // power schemes: 00 low power, 01 high performance, 1x flexible
    localparam logic [1:0] LOW_POWER_SCHEME = 2'h0;
    localparam logic [1:0] HIGH_PERFORMANCE_SCHEME = 2'h1;
    localparam int FLEXIBLE_BIT = 1;
    localparam logic [3:0] MAX_RATE_SELECT = 4'hC;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam real STEP_TIME_US = 312.5;
    localparam real CLK_PERIOD_NS = 10.0;
    localparam int STEP_CYCLES = int'(STEP_TIME_US * 1000.0 / CLK_PERIOD_NS);

    typedef enum logic {MODE_ACTIVE, MODE_REST} mode_type;

    typedef struct packed {
        logic outside_threshold_flag;
        logic within_threshold_flag;
        logic orientation_flag;
        logic buffer_event_flag;
    } event_flags_type;

    typedef struct packed {
        logic [1:0] power_select;
        logic [3:0] rate_select;
        logic [2:0] decimation;
        logic [11:0] idle_time;
    } mode_config_type;
endpackage
`default_nettype wire

// File: dv/auto_wake_sleep_idle_timing_tb_top.sv
// self-checking bench: register map, inactivity timing, wake, buffer gate, flexible periods
`default_nettype none
module auto_wake_sleep_idle_timing_tb_top import wake_rest_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // short step keeps the run small; expected period lengths scale with it
    localparam int STEP = 4;
    logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
    logic awready, wready, arready, buffer_empty, rest_mode, period_strobe, blocked, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    event_flags_type event_flags;
    int mismatches = 0;
    int total_checks = 0;
    int n, lim, ra, rr, idl, dc;

    auto_wake_sleep_idle_timing #(.STEP_COUNT(STEP)) auto_wake_sleep_idle_timing_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .event_flags(event_flags), .buffer_empty(buffer_empty), .rest_mode(rest_mode),
        .period_strobe(period_strobe), .buffer_input_blocked(blocked), .irq(irq));

    always #5 aclk = ~aclk;

    function automatic int pcyc(input logic flex, input int r, input int idle, input int d);
        return STEP * (flex ? idle + (1 << d) : (1 << r));
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bready and rready stay high, so every answer is taken at the edge it is seen
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        int i = 0;
        awaddr <= idx << 2;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && ++i < 99);
        if (i >= 99) mismatches++;
        rs = bresp;
    endtask
    task automatic rdr(input logic [7:0] idx);
        int i = 0;
        araddr <= idx << 2;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && ++i < 99);
        if (i >= 99) mismatches++;
        rd = rdata;
        rs = rresp;
    endtask
    task automatic wait_sig(input logic which);
        int i = 0;
        do @(posedge aclk);
        while ((which ? rest_mode : period_strobe) !== 1'b1 && ++i < 9000);
        if (i >= 9000) mismatches++;
    endtask
    // first strobe after a change may close a partial period, so skip it
    task automatic per(input int exp, input string nm);
        int c = 1;
        wait_sig(1'b0);
        wait_sig(1'b0);
        @(posedge aclk);
        while (period_strobe !== 1'b1 && c < 9000) begin
            @(posedge aclk);
            c++;
        end
        check(nm, c, exp);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #200us;
        mismatches++;
        results();
    end

    initial begin
        aclk = 1'b0;
        aresetn <= 1'b0;
        {awvalid, wvalid, arvalid, buffer_empty} <= 4'h0;
        {bready, rready, wstrb} <= 6'h3F;
        {awaddr, araddr, wdata} <= 48'h0;
        event_flags <= '0;
        void'($urandom(32'h9E232EC0));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++) begin
            rdr(8'(IDX_ACTIVE_IDLE_LOW + i));
            check("reg reset", rd, RESET_WORD);
            v = $urandom;
            wr(8'(IDX_ACTIVE_IDLE_LOW + i), v);
            rdr(8'(IDX_ACTIVE_IDLE_LOW + i));
            check("reg rw", rd, v & (i[0] ? 32'h0000000F : 32'h000000FF));
            wr(8'(IDX_ACTIVE_IDLE_LOW + i), RESET_WORD);
        end
        rdr(8'h30);
        check("unmapped rresp", rs, RESP_SLVERR);
        check("unmapped rdata", rd, RESET_WORD);
        wr(8'h30, 32'h000000FF);
        check("unmapped bresp", rs, RESP_SLVERR);
        $display("test registers done");
        ra = $urandom_range(2);
        rr = $urandom_range(2);
        lim = $urandom_range(5, 2);
        wr(IDX_MODE_CONTROL, 32'h000001C0);
        wr(IDX_RATE_CONTROL, 32'(rr * 16 + ra));
        per(pcyc(0, ra, 0, 0), "active period");
        check("zero limit stays active", rest_mode, 1'b0);
        event_flags.outside_threshold_flag <= 1'b1;
        wr(IDX_INACT_COUNT_LOW, lim);
        event_flags <= '0;
        // a strobe from a period that ended while the event still cleared is not counted
        @(posedge aclk);
        n = 0;
        do begin
            @(posedge aclk);
            n += period_strobe;
        end while (rest_mode !== 1'b1 && n < 99);
        check("periods to rest", n, lim);
        per(pcyc(0, rr, 0, 0), "rest period");
        rdr(IDX_IRQ_STATUS);
        check("irq rest bit", rd[IRQ_REST_BIT], 1'b1);
        wr(IDX_IRQ_MASK, 32'h00000003);
        @(posedge aclk);
        check("irq raised", irq, 1'b1);
        wr(IDX_IRQ_STATUS, 32'h00000003);
        @(posedge aclk);
        check("irq cleared", irq, 1'b0);
        $display("test inactivity done");
        event_flags.buffer_event_flag <= 1'b1;
        repeat (4) @(posedge aclk);
        check("buffer flag no wake", rest_mode, 1'b1);
        event_flags <= '0;
        for (int k = 0; k < 3; k++) begin
            wr(IDX_MODE_CONTROL, 32'h00000040 << k);
            wait_sig(1'b1);
            event_flags <= 4'(2 << ((k + 1) % 3));
            repeat (4) @(posedge aclk);
            check("disabled event", rest_mode, 1'b1);
            event_flags <= 4'(2 << k);
            repeat (2) @(posedge aclk);
            check("wake", rest_mode, 1'b0);
            event_flags <= '0;
        end
        $display("test wake done");
        for (int o = 0; o < 2; o++) begin
            wr(IDX_INACT_COUNT_LOW, RESET_WORD);
            repeat (100) @(posedge aclk);
            check("zero limit", rest_mode, 1'b0);
            wr(IDX_MODE_CONTROL, 32'(o) << BUF_WAKE_BIT);
            wr(IDX_INACT_COUNT_LOW, 32'h00000003);
            repeat (60) begin
                event_flags.buffer_event_flag <= 1'b1;
                @(posedge aclk);
                event_flags.buffer_event_flag <= 1'b0;
                @(posedge aclk);
            end
            check("buffer drain", rest_mode, o == 0);
        end
        $display("test buffer option done");
        wr(IDX_MODE_CONTROL, 32'h00000120);
        wr(IDX_INACT_COUNT_LOW, 32'h00000002);
        wait_sig(1'b1);
        @(posedge aclk);
        check("gate on rest entry", blocked, 1'b1);
        buffer_empty <= 1'b1;
        repeat (3) @(posedge aclk);
        check("gate released", blocked, 1'b0);
        buffer_empty <= 1'b0;
        event_flags.outside_threshold_flag <= 1'b1;
        repeat (3) @(posedge aclk);
        check("gate on wake", blocked, 1'b1);
        rdr(IDX_STATUS);
        check("status word", rd, 32'h00000002);
        event_flags <= '0;
        $display("test buffer gate done");
        idl = $urandom_range(300, 1);
        dc = $urandom_range(3);
        n = $urandom_range(40, 1);
        wr(IDX_INACT_COUNT_LOW, RESET_WORD);
        // fixed rate fields at their slowest must be ignored in flexible mode
        wr(IDX_MODE_CONTROL, 32'h0000010A);
        wr(IDX_RATE_CONTROL, (32'(dc) << ACT_DEC_LSB) | (32'(dc) << REST_DEC_LSB) | 32'hCC);
        wr(IDX_ACTIVE_IDLE_LOW, idl[7:0]);
        wr(IDX_ACTIVE_IDLE_HIGH, {24'h0, 4'hF, idl[11:8]});
        wr(IDX_REST_IDLE_LOW, n[7:0]);
        wr(IDX_REST_IDLE_HIGH, 32'h000000F0);
        per(pcyc(1, 0, idl, dc), "flex active period");
        wr(IDX_INACT_COUNT_LOW, 32'h00000001);
        wait_sig(1'b1);
        per(pcyc(1, 0, n, dc), "flex rest period");
        $display("test flexible done");
        results();
    end
endmodule
`default_nettype wire
